// [dv/ilc_checker.sv]
// port assertions for the input line conditioner
`timescale 1ns/10ps
module ilc_checker
	import ilc_pkg::*;
(
	// clock, reset, settings
	input wire logic                 ref_clk_in,
	input wire logic                 rst_in,
	input wire logic                 clk_en_in,
	input wire logic [SEL_W-1:0]     line_picker_in,
	input wire logic                 time_wr_in,
	input wire logic [TIME_W-1:0]    glitch_filter_time_us_in,
	input wire logic                 term_wr_in,
	input wire logic                 term_resistor_on_in,
	input wire logic                 route_wr_in,
	// results
	input wire logic [TIME_W-1:0]    glitch_filter_time_us_out,
	input wire logic                 polarity_flip_out,
	input wire logic                 term_resistor_on_out,
	input wire logic [NUM_LINES-1:0] term_en_out,
	input wire logic [NUM_LINES-1:0] line_out,
	input wire logic                 acq_start_trig_out,
	input wire logic                 frame_start_trig_out,
	input wire logic                 line_start_trig_out,
	input wire logic                 enc_phase_a_out,
	input wire logic                 enc_phase_b_out
);
	// route checks only hold while the reset routes are in place
	logic routed;
	logic next_routed;
	always_comb next_routed = routed | (route_wr_in & clk_en_in);
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) routed <= 1'b0;
		else routed <= next_routed;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_TERM_RST: assert property ($fell(rst_in) |-> term_en_out == 3'h0 && line_out == 3'h0)
		else $error("outputs not clear after reset");
	AST_TERM_WR: assert property (clk_en_in && term_wr_in && line_picker_in != 2'h3 |=>
		term_en_out[$past(line_picker_in)] == $past(term_resistor_on_in))
		else $error("termination write not applied");
	AST_TERM_HOLD: assert property (!(clk_en_in && term_wr_in) || line_picker_in == 2'h3 |=>
		$stable(term_en_out)) else $error("termination changed without write");
	AST_FREEZE: assert property (!clk_en_in |=> $stable(line_out))
		else $error("line moved while frozen");
	AST_RB_NONE: assert property (clk_en_in && line_picker_in == 2'h3 |=>
		glitch_filter_time_us_out == TIME_RESET && !polarity_flip_out && !term_resistor_on_out)
		else $error("readback not clear for no line");
	AST_TIME_CLAMP: assert property (clk_en_in && time_wr_in && line_picker_in != 2'h3
		##1 clk_en_in && $stable(line_picker_in) |=> glitch_filter_time_us_out ==
		(($past(glitch_filter_time_us_in, 2) > TIME_LIMIT) ? TIME_LIMIT :
		$past(glitch_filter_time_us_in, 2))) else $error("filter time readback wrong");
	AST_ROUTE_L1: assert property (!routed && $past(clk_en_in) |->
		acq_start_trig_out == $past(line_out[0]) && line_start_trig_out == $past(line_out[0])
		&& enc_phase_a_out == $past(line_out[0])) else $error("line one routes wrong");
	AST_ROUTE_L2: assert property (!routed && $past(clk_en_in) |->
		enc_phase_b_out == $past(line_out[1])) else $error("phase b route wrong");
	AST_ROUTE_L3: assert property (!routed && $past(clk_en_in) |->
		frame_start_trig_out == $past(line_out[2])) else $error("frame route wrong");
	cover property (clk_en_in && term_wr_in);
	cover property (clk_en_in && time_wr_in);
	cover property (clk_en_in && route_wr_in);
endmodule // ilc_checker
bind ilc_top ilc_checker ilc_checker_inst (.ref_clk_in, .rst_in, .clk_en_in, .line_picker_in,
	.time_wr_in, .glitch_filter_time_us_in, .term_wr_in, .term_resistor_on_in, .route_wr_in,
	.glitch_filter_time_us_out, .polarity_flip_out, .term_resistor_on_out, .term_en_out,
	.line_out, .acq_start_trig_out, .frame_start_trig_out, .line_start_trig_out,
	.enc_phase_a_out, .enc_phase_b_out);

// [dv/ilc_src_model.sv]
// signal source model driving the three raw input pins
`timescale 1ns/10ps
module ilc_src_model
	import ilc_pkg::*;
#(
	parameter logic [2:0] DIFF_LINES = 3'h4
)(
	// clock
	input  wire logic                 ref_clk_in,
	// wanted levels and termination state
	input  wire logic [NUM_LINES-1:0] level_in,
	input  wire logic [NUM_LINES-1:0] term_en_in,
	// pins
	output logic      [NUM_LINES-1:0] raw_out
);
	logic [NUM_LINES-1:0] next_raw;
	// a wrongly terminated receiver shows the wrong level, never a kind one
	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			next_raw[i] = level_in[i] ^ (term_en_in[i] != DIFF_LINES[i]);
		end
	end
	always_ff @(posedge ref_clk_in) begin
		raw_out <= next_raw;
	end
endmodule // ilc_src_model

// [dv/tb_ilc_top.sv]
// self-checking testbench for the input line conditioner
`timescale 1ns/10ps
module tb_ilc_top
	import ilc_pkg::*;
;
	logic        ref_clk_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        clk_en     = 1'b1;
	logic [1:0]  picker     = 2'h0;
	logic        time_wr    = 1'b0;
	logic        flip_wr    = 1'b0;
	logic        term_wr    = 1'b0;
	logic        route_wr   = 1'b0;
	logic [19:0] tval       = 20'h00000;
	logic [2:0]  level      = 3'h0;
	logic [2:0]  raw;
	logic [2:0]  term_en;
	logic [2:0]  line;
	logic [19:0] time_rb;
	logic        flip_rb;
	logic        term_rb;
	logic [4:0]  trig;
	int          fail_count  = 0;
	int          comparisons = 0;
	int          n;
	ilc_top ilc_top_inst (.ref_clk_in, .rst_in, .clk_en_in(clk_en), .line_picker_in(picker),
		.time_wr_in(time_wr), .glitch_filter_time_us_in(tval), .flip_wr_in(flip_wr),
		.polarity_flip_in(tval[0]), .term_wr_in(term_wr), .term_resistor_on_in(tval[0]),
		.glitch_filter_time_us_out(time_rb), .polarity_flip_out(flip_rb),
		.term_resistor_on_out(term_rb), .route_wr_in(route_wr), .route_target_in(tval[2:0]),
		.route_line_in(picker), .raw_line_in(raw), .term_en_out(term_en), .line_out(line),
		.acq_start_trig_out(trig[0]), .frame_start_trig_out(trig[1]),
		.line_start_trig_out(trig[2]), .enc_phase_a_out(trig[3]), .enc_phase_b_out(trig[4]));
	ilc_src_model ilc_src_model_inst (.ref_clk_in, .level_in(level), .term_en_in(term_en),
		.raw_out(raw));
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// kind: 0 filter time, 1 polarity, 2 termination, 3 route (target in v)
	task automatic wr(input int kind, input logic [1:0] sel, input logic [19:0] v);
		@(posedge ref_clk_in);
		picker   <= sel;
		tval     <= v;
		time_wr  <= (kind == 0);
		flip_wr  <= (kind == 1);
		term_wr  <= (kind == 2);
		route_wr <= (kind == 3);
		@(posedge ref_clk_in);
		{time_wr, flip_wr, term_wr, route_wr} <= 4'h0;
		#1;
	endtask
	task automatic wait_line(input int i, input logic v, input int lim);
		n = 0;
		while (line[i] !== v && n < lim) begin
			step(1);
			n++;
		end
	endtask
	task automatic test_term;
		wr(2, SEL_LINE3, 20'h00001);
		chk(term_en, 20'h4);
		step(1);
		chk(term_rb, 20'h1);
		wr(2, 2'h3, 20'h00000);
		step(1);
		chk(term_en, 20'h4);
		chk(term_rb, 20'h0);
		wait_line(2, 1'b0, 8);
		chk(line, 20'h0);
	endtask
	task automatic test_zero;
		@(posedge ref_clk_in);
		level <= 3'h2;
		step(3);
		chk(line, 20'h0);
		step(1);
		chk(line, 20'h2);
	endtask
	task automatic test_debounce;
		wr(0, SEL_LINE1, 20'h00001);
		step(1);
		chk(time_rb, 20'h00001);
		@(posedge ref_clk_in);
		level[0] <= 1'b1;
		repeat (50) @(posedge ref_clk_in);
		level[0] <= 1'b0;
		wait_line(0, 1'b1, 300);
		chk(20'(n), 20'h0012C);
		@(posedge ref_clk_in);
		level[0] <= 1'b1;
		wait_line(0, 1'b1, 400);
		chk(20'(n >= 200 && n <= 215), 20'h1);
		@(posedge ref_clk_in);
		level[0] <= 1'b0;
		repeat (100) @(posedge ref_clk_in);
		wr(0, SEL_LINE1, 20'h00001);
		wait_line(0, 1'b0, 400);
		chk(20'(n >= 195 && n <= 215), 20'h1);
		wr(0, SEL_LINE3, 20'hFFFFF);
		step(1);
		chk(time_rb, TIME_LIMIT);
	endtask
	task automatic test_flip_route;
		wr(1, SEL_LINE3, 20'h00001);
		step(1);
		chk(line, 20'h6);
		chk(flip_rb, 20'h1);
		step(1);
		chk(trig, 20'h12);
		wr(3, SEL_LINE1, 20'h00004);
		step(1);
		chk(trig, 20'h02);
		wr(3, 2'h3, 20'h00001);
		step(1);
		chk(trig, 20'h02);
		wr(3, SEL_LINE3, 20'h00000);
		step(1);
		chk(trig, 20'h03);
		// writes taken while frozen must be lost
		@(posedge ref_clk_in);
		clk_en <= 1'b0;
		wr(2, SEL_LINE1, 20'h00001);
		chk(term_en, 20'h4);
		@(posedge ref_clk_in);
		clk_en <= 1'b1;
	endtask
	task automatic complete_run;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		test_term();
		test_zero();
		test_debounce();
		test_flip_route();
		complete_run();
	end
	// whole run needs about 900 cycles
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		fail_count++;
		complete_run();
	end
endmodule // tb_ilc_top

// [pkg/ilc_pkg.sv]
// constants and types for the input line conditioner
package ilc_pkg;
	// ****************************************
	// line count and selection
	// ****************************************
	localparam int unsigned NUM_LINES      = 3;
	localparam int unsigned SEL_W          = 2;
	localparam logic [1:0]  SEL_LINE1      = 2'h0;
	localparam logic [1:0]  SEL_LINE2      = 2'h1;
	localparam logic [1:0]  SEL_LINE3      = 2'h2;
	// ****************************************
	// debounce timing
	// ****************************************
	localparam int unsigned CLK_MHZ        = 200;
	localparam int unsigned TIME_W         = 20;
	localparam int unsigned MAX_TIME_US    = 1000000;
	localparam int unsigned CYC_PER_US     = CLK_MHZ;
	localparam int unsigned TICK_W         = 8;
	localparam logic [7:0]  TICK_LAST      = 8'(CYC_PER_US - 1);
	localparam logic [19:0] TIME_RESET     = 20'h00000;
	localparam logic [19:0] TIME_LIMIT     = 20'(MAX_TIME_US);
	// ****************************************
	// reset values of per-line settings
	// ****************************************
	localparam logic        FLIP_RESET     = 1'b0;
	localparam logic        TERM_RESET     = 1'b0;
	// ****************************************
	// trigger routing targets
	// ****************************************
	localparam int unsigned NUM_TARGETS    = 5;
	localparam int unsigned TGT_ACQ_START  = 0;
	localparam int unsigned TGT_FRAME      = 1;
	localparam int unsigned TGT_LINE       = 2;
	localparam int unsigned TGT_ENC_A      = 3;
	localparam int unsigned TGT_ENC_B      = 4;
	localparam logic [1:0]  ROUTE_ACQ_RST  = SEL_LINE1;
	localparam logic [1:0]  ROUTE_FRM_RST  = SEL_LINE3;
	localparam logic [1:0]  ROUTE_LIN_RST  = SEL_LINE1;
	localparam logic [1:0]  ROUTE_ENA_RST  = SEL_LINE1;
	localparam logic [1:0]  ROUTE_ENB_RST  = SEL_LINE2;
	// ****************************************
	// filter states
	// ****************************************
	typedef enum logic [1:0] {
		FLT_STABLE  = 2'b01,
		FLT_QUALIFY = 2'b10
	} ilc_flt_state_type;
endpackage

// [rtl/ilc_debounce.sv]
// one line: synchroniser, debounce filter and polarity flip
`timescale 1ns/10ps
module ilc_debounce
	import ilc_pkg::*;
(
	// clock and reset
	input  wire logic              ref_clk_in,
	input  wire logic              rst_in,
	input  wire logic              clk_en_in,
	// per-line settings
	input  wire logic [TIME_W-1:0] filter_time_us_in,
	input  wire logic              polarity_flip_in,
	input  wire logic              restart_in,
	// raw pin and result
	input  wire logic              raw_in,
	output logic                   line_out
);
	// ****************************************
	// state
	// ****************************************
	logic              sync_a;
	logic              sync_b;
	logic              next_sync_a;
	logic              next_sync_b;
	ilc_flt_state_type state;
	ilc_flt_state_type next_state;
	logic              level;
	logic              next_level;
	logic [TICK_W-1:0] tick;
	logic [TICK_W-1:0] next_tick;
	logic [TIME_W-1:0] us_cnt;
	logic [TIME_W-1:0] next_us_cnt;
	logic              flipped;
	logic              next_flipped;

	// ****************************************
	// next values
	// ****************************************
	always_comb begin
		next_sync_a  = raw_in;
		next_sync_b  = sync_a;
		next_state   = state;
		next_level   = level;
		next_tick    = tick;
		next_us_cnt  = us_cnt;
		if (filter_time_us_in == TIME_RESET) begin
			// no filter time: pass straight through
			next_state = FLT_STABLE;
			next_level = sync_b;
			next_tick  = '0;
			next_us_cnt = '0;
		end else if (restart_in) begin
			next_state  = FLT_STABLE;
			next_tick   = '0;
			next_us_cnt = '0;
		end else begin
			case (state)
				FLT_STABLE: begin
					next_tick   = '0;
					next_us_cnt = '0;
					if (sync_b != level) begin
						next_state = FLT_QUALIFY;
					end
				end
				FLT_QUALIFY: begin
					if (sync_b == level) begin
						// bounced back before the time ran out
						next_state  = FLT_STABLE;
					end else if (tick == TICK_LAST) begin
						next_tick = '0;
						if (us_cnt + 20'h00001 >= filter_time_us_in) begin
							next_level = sync_b;
							next_state = FLT_STABLE;
						end else begin
							next_us_cnt = TIME_W'(us_cnt + 20'h00001);
						end
					end else begin
						next_tick = TICK_W'(tick + 8'h01);
					end
				end
				default: begin
					next_state = FLT_STABLE;
				end
			endcase
		end
		next_flipped = next_level ^ polarity_flip_in;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync_a  <= 1'b0;
			sync_b  <= 1'b0;
			state   <= FLT_STABLE;
			level   <= 1'b0;
			tick    <= '0;
			us_cnt  <= '0;
			flipped <= FLIP_RESET;
		end else if (clk_en_in) begin
			sync_a  <= next_sync_a;
			sync_b  <= next_sync_b;
			state   <= next_state;
			level   <= next_level;
			tick    <= next_tick;
			us_cnt  <= next_us_cnt;
			flipped <= next_flipped;
		end
	end

	assign line_out = flipped;
endmodule // ilc_debounce

// [rtl/ilc_top.sv]
// input line conditioner: three filtered, invertible, terminated input lines
// Behaviour
// - three independent lines with separate settings
// - each line has its own debounce filter
// - new level accepted after stable programmed time
// - filter time in microseconds, zero to one second
// - polarity flip inverts line when set
// - picker selects line before per-line writes
// - per-line termination enable output
// - each line routable to five trigger targets
`timescale 1ns/10ps
module ilc_top
	import ilc_pkg::*;
(
	// clock, reset, enable
	input  wire logic                   ref_clk_in,
	input  wire logic                   rst_in,
	input  wire logic                   clk_en_in,
	// settings port
	input  wire logic [SEL_W-1:0]       line_picker_in,
	input  wire logic                   time_wr_in,
	input  wire logic [TIME_W-1:0]      glitch_filter_time_us_in,
	input  wire logic                   flip_wr_in,
	input  wire logic                   polarity_flip_in,
	input  wire logic                   term_wr_in,
	input  wire logic                   term_resistor_on_in,
	// settings readback of the picked line
	output logic [TIME_W-1:0]           glitch_filter_time_us_out,
	output logic                        polarity_flip_out,
	output logic                        term_resistor_on_out,
	// trigger routing
	input  wire logic                   route_wr_in,
	input  wire logic [2:0]             route_target_in,
	input  wire logic [SEL_W-1:0]       route_line_in,
	// pins and results
	input  wire logic [NUM_LINES-1:0]   raw_line_in,
	output logic [NUM_LINES-1:0]        term_en_out,
	output logic [NUM_LINES-1:0]        line_out,
	output logic                        acq_start_trig_out,
	output logic                        frame_start_trig_out,
	output logic                        line_start_trig_out,
	output logic                        enc_phase_a_out,
	output logic                        enc_phase_b_out
);
	// ****************************************
	// per-line settings
	// ****************************************
	logic [TIME_W-1:0]    time_us   [NUM_LINES];
	logic [TIME_W-1:0]    next_time_us [NUM_LINES];
	logic [NUM_LINES-1:0] flip;
	logic [NUM_LINES-1:0] next_flip;
	logic [NUM_LINES-1:0] term;
	logic [NUM_LINES-1:0] next_term;
	logic [NUM_LINES-1:0] restart;
	logic [NUM_LINES-1:0] next_restart;
	logic [SEL_W-1:0]     route     [NUM_TARGETS];
	logic [SEL_W-1:0]     next_route [NUM_TARGETS];
	logic [NUM_LINES-1:0] filt;
	logic [NUM_TARGETS-1:0] trig;
	logic [NUM_TARGETS-1:0] next_trig;
	logic [TIME_W-1:0]    rd_time;
	logic                 rd_flip;
	logic                 rd_term;
	logic [TIME_W-1:0]    next_rd_time;
	logic                 next_rd_flip;
	logic                 next_rd_term;

	// ****************************************
	// helpers
	// ****************************************
	// picks a conditioned line; an unused code reads low
	function automatic logic pick_line(input logic [NUM_LINES-1:0] l, input logic [SEL_W-1:0] s);
		pick_line = (s < SEL_W'(NUM_LINES)) ? l[s] : 1'b0;
	endfunction

	// clamps the time to the supported range
	function automatic logic [TIME_W-1:0] clamp_time(input logic [TIME_W-1:0] t);
		clamp_time = (t > TIME_LIMIT) ? TIME_LIMIT : t;
	endfunction

	// ****************************************
	// settings writes
	// ****************************************
	always_comb begin
		next_flip    = flip;
		next_term    = term;
		next_restart = '0;
		for (int i = 0; i < NUM_LINES; i++) begin
			next_time_us[i] = time_us[i];
			// writes only land on the picked line
			if (line_picker_in == SEL_W'(i)) begin
				if (time_wr_in) begin
					next_time_us[i] = clamp_time(glitch_filter_time_us_in);
					next_restart[i] = 1'b1;
				end
				if (flip_wr_in) begin
					next_flip[i] = polarity_flip_in;
				end
				if (term_wr_in) begin
					next_term[i] = term_resistor_on_in;
				end
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NUM_LINES; i++) begin
				time_us[i] <= TIME_RESET;
			end
			flip    <= {NUM_LINES{FLIP_RESET}};
			term    <= {NUM_LINES{TERM_RESET}};
			restart <= '0;
		end else if (clk_en_in) begin
			time_us <= next_time_us;
			flip    <= next_flip;
			term    <= next_term;
			restart <= next_restart;
		end
	end

	// ****************************************
	// trigger routing
	// ****************************************
	// a refused route write keeps the old source, so a target never goes dead
	always_comb begin
		for (int t = 0; t < NUM_TARGETS; t++) begin
			next_route[t] = route[t];
			if (route_wr_in && route_target_in == 3'(t) && route_line_in < SEL_W'(NUM_LINES)) begin
				next_route[t] = route_line_in;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			route[TGT_ACQ_START] <= ROUTE_ACQ_RST;
			route[TGT_FRAME]     <= ROUTE_FRM_RST;
			route[TGT_LINE]      <= ROUTE_LIN_RST;
			route[TGT_ENC_A]     <= ROUTE_ENA_RST;
			route[TGT_ENC_B]     <= ROUTE_ENB_RST;
		end else if (clk_en_in) begin
			route <= next_route;
		end
	end

	// ****************************************
	// routed trigger outputs
	// ****************************************
	// registered so each output leaves a flop; costs one cycle behind line_out
	always_comb begin
		for (int t = 0; t < NUM_TARGETS; t++) begin
			next_trig[t] = pick_line(filt, route[t]);
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			trig <= '0;
		end else if (clk_en_in) begin
			trig <= next_trig;
		end
	end

	// ****************************************
	// readback of the picked line
	// ****************************************
	always_comb begin
		next_rd_time = '0;
		next_rd_flip = 1'b0;
		next_rd_term = 1'b0;
		for (int i = 0; i < NUM_LINES; i++) begin
			if (line_picker_in == SEL_W'(i)) begin
				next_rd_time = time_us[i];
				next_rd_flip = flip[i];
				next_rd_term = term[i];
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_time <= TIME_RESET;
			rd_flip <= FLIP_RESET;
			rd_term <= TERM_RESET;
		end else if (clk_en_in) begin
			rd_time <= next_rd_time;
			rd_flip <= next_rd_flip;
			rd_term <= next_rd_term;
		end
	end

	// ****************************************
	// conditioning paths
	// ****************************************
	for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
		ilc_debounce ilc_debounce_inst (
			.ref_clk_in        (ref_clk_in),
			.rst_in            (rst_in),
			.clk_en_in         (clk_en_in),
			.filter_time_us_in (time_us[g]),
			.polarity_flip_in  (flip[g]),
			.restart_in        (restart[g]),
			.raw_in            (raw_line_in[g]),
			.line_out          (filt[g])
		);
	end

	assign line_out                  = filt;
	assign term_en_out               = term;
	assign glitch_filter_time_us_out = rd_time;
	assign polarity_flip_out         = rd_flip;
	assign term_resistor_on_out      = rd_term;
	assign acq_start_trig_out        = trig[TGT_ACQ_START];
	assign frame_start_trig_out      = trig[TGT_FRAME];
	assign line_start_trig_out       = trig[TGT_LINE];
	assign enc_phase_a_out           = trig[TGT_ENC_A];
	assign enc_phase_b_out           = trig[TGT_ENC_B];
endmodule // ilc_top
